// *** dv/sync_peer.sv ***
// Far-end serial device clocked by the port's shift clock
`timescale 1ns/1ps
module sync_peer (
  // Shift clock from the port
  input  wire logic i_ck,
  input  wire logic i_ck_oe,
  // Shared data line
  input  wire logic i_dt,
  input  wire logic i_dt_oe,
  output logic      o_dt
);
  logic q[$];
  logic send[$];
  int   falls;

  initial o_dt = 1'b0;
  // Take a bit on each falling clock while the port drives data
  always @(negedge i_ck) begin
    if (i_ck_oe) begin
      falls++;
    end
    if (i_ck_oe && i_dt_oe) begin
      q.push_back(i_dt);
    end
  end
  // Present bits on rising clock; toggle when idle so no stale level
  always @(posedge i_ck) begin
    if (i_ck_oe && !i_dt_oe) begin
      o_dt <= (send.size() > 0) ? send.pop_front() : !o_dt;
    end
  end
endmodule

// *** dv/usart_sync_master_properties.sv ***
// Concurrent checks on the serial port top-level pins
`timescale 1ns/1ps
module usart_sync_master_properties #(
  parameter int RX_DEPTH = 2
) (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_rst_b,
  input wire logic        i_clk_en,
  // APB
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Pins
  input wire logic        o_clock_pin_out,
  input wire logic        o_clock_pin_oe,
  input wire logic        i_data_pin,
  input wire logic        o_data_pin_out,
  input wire logic        o_data_pin_oe
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // ----------------------------------------------------------------
  // Register bus and pin relations
  // ----------------------------------------------------------------
  a_ready_one_wait: assert property ($rose(i_penable) && i_psel && i_clk_en |=> o_pready)
    else $error("ready not one cycle after access");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  a_ready_needs_req: assert property (o_pready |-> i_psel && i_penable)
    else $error("ready without request");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  a_rdata_high_zero: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_data_stable_fall: assert property ($fell(o_clock_pin_out) && o_data_pin_oe |-> $stable(o_data_pin_out))
    else $error("data moved at falling clock");
  a_data_needs_clock: assert property (o_data_pin_oe |-> o_clock_pin_oe)
    else $error("data driven with clock floating");
  a_data_on_rise: assert property (o_data_pin_oe && $past(o_data_pin_oe) && $changed(o_data_pin_out)
    |-> $rose(o_clock_pin_out))
    else $error("data changed off rising clock");
  a_quiet_after_reset: assert property ($rose(i_rst_b) |-> !o_pready && !o_clock_pin_oe && !o_data_pin_oe)
    else $error("outputs active after reset");

  // Main scenarios reached
  c_refused: cover property (o_pslverr);
  c_tx_bit: cover property ($fell(o_clock_pin_out) && o_data_pin_oe);
  c_rx_bit: cover property ($fell(o_clock_pin_out) && o_clock_pin_oe && !o_data_pin_oe);
endmodule

bind usart_sync_master usart_sync_master_properties #(.RX_DEPTH(RX_DEPTH)) u_props (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(i_clk_en), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_clock_pin_out(o_clock_pin_out), .o_clock_pin_oe(o_clock_pin_oe),
  .i_data_pin(i_data_pin), .o_data_pin_out(o_data_pin_out), .o_data_pin_oe(o_data_pin_oe));

// *** dv/usart_sync_master_tb.sv ***
// Self-checking bench for the synchronous master serial port
`timescale 1ns/1ps
`include "usart_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module usart_sync_master_tb
  import usart_pkg::*;
;
  localparam logic [7:0] A_RXC = 8'(`USART_IDX_RX_STAT * 4);
  localparam logic [7:0] A_RXD = 8'(`USART_IDX_RX_DATA * 4);
  localparam logic [7:0] A_TXC = 8'(`USART_IDX_TX_STAT * 4);
  localparam logic [7:0] A_TXD = 8'(`USART_IDX_TX_DATA * 4);
  localparam logic [7:0] A_BD  = 8'(`USART_IDX_BAUD * 4);
  localparam logic [7:0] A_FLG = 8'(`USART_IDX_FLAGS * 4 + `USART_BANK1_OFS);
  localparam logic [7:0] A_ENA = 8'(`USART_IDX_ENABLES * 4 + `USART_BANK1_OFS);

  logic        i_clock = 1'b0;
  logic        rst_b   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, ck, ck_oe, dt, dt_oe, peer_dt, er, b, e;
  logic [31:0] rd;
  logic [7:0]  w0;
  logic [7:0]  rxb[3];
  logic        exp_q[$];
  int          err_total, comparisons, n;
  wire         dt_wire = dt_oe ? dt : peer_dt;

  always #2.5 i_clock = ~i_clock;

  usart_sync_master DUT (
    .i_clock(i_clock), .i_rst_b(rst_b), .i_clk_en(1'b1), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_clock_pin_out(ck), .o_clock_pin_oe(ck_oe), .i_data_pin(dt_wire),
    .o_data_pin_out(dt), .o_data_pin_oe(dt_oe));
  sync_peer u_peer (.i_ck(ck), .i_ck_oe(ck_oe), .i_dt(dt_wire), .i_dt_oe(dt_oe), .o_dt(peer_dt));

  // ----------------------------------------------------------------
  // Bus tasks and reference model
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'($urandom), d};
    @(posedge i_clock);
    penable <= 1'b1;
    do @(posedge i_clock); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    `CHK(rd, {24'h0, x})
  endtask
  // Queue the expected bits of one word, least significant first
  task automatic put(input logic [7:0] d, input logic nine, input logic n9);
    apb(1'b1, A_TXD, d);
    for (int i = 0; i < 8; i++) exp_q.push_back(d[i]);
    if (nine) exp_q.push_back(n9);
  endtask
  task automatic drain();
    int k;
    k = 0;
    while (u_peer.q.size() < exp_q.size() && k < 3000) begin @(posedge i_clock); k++; end
    repeat (12) @(posedge i_clock);
    while (exp_q.size() > 0) begin
      b = u_peer.q.pop_front();
      e = exp_q.pop_front();
      `CHK(b, e)
    end
  endtask
  // Wait for a number of falling pin clocks; a stall counts as a mismatch
  task automatic wait_falls(input int c);
    int lim, k;
    lim = u_peer.falls + c;
    k = 0;
    while (u_peer.falls < lim && k < 5000) begin @(posedge i_clock); k++; end
    if (k >= 5000) err_total++;
    repeat (10) @(posedge i_clock);
  endtask
  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(90617));
    repeat (3) @(posedge i_clock);
    rst_b <= 1'b1;
    rchk(A_RXC, 8'h00);
    rchk(A_TXC, 8'h02);
    rchk(A_FLG, 8'h02);
    rchk(A_ENA, 8'h00);
    apb(1'b0, 8'h04, 8'h00);
    `CHK(er, 1'b1)
    apb(1'b1, A_FLG, 8'h00);
    rchk(A_FLG, 8'h02);
    w0 = 8'($urandom);
    apb(1'b1, A_ENA, w0);
    rchk(A_ENA, w0 & 8'h03);
    w0 = 8'($urandom);
    apb(1'b1, A_BD, w0);
    rchk(A_BD, w0);
    apb(1'b1, A_BD, 8'h04);
    // Buffer loaded before enabling, then a second word back to back
    apb(1'b1, A_RXC, 8'h80);
    apb(1'b1, A_TXC, 8'h90);
    put(8'($urandom), 1'b0, 1'b0);
    rchk(A_FLG, 8'h00);
    apb(1'b1, A_TXC, 8'hb0);
    repeat (12) @(posedge i_clock);
    rchk(A_FLG, 8'h02);
    put(8'($urandom), 1'b0, 1'b0);
    rchk(A_FLG, 8'h00);
    drain();
    rchk(A_TXC, 8'hb2);
    rchk(A_FLG, 8'h02);
    // Nine-bit words with both ninth values
    for (n = 0; n < 2; n++) begin
      apb(1'b1, A_TXC, 8'hf0 | 8'(n));
      put(8'($urandom), 1'b1, n[0]);
      drain();
    end
    // Abort in mid-word by dropping the transmit enable
    apb(1'b1, A_TXC, 8'hb0);
    put(8'($urandom), 1'b0, 1'b0);
    repeat (30) @(posedge i_clock);
    apb(1'b1, A_TXC, 8'h90);
    repeat (3) @(posedge i_clock);
    `CHK(dt_oe, 1'b0)
    `CHK(ck_oe, 1'b0)
    rchk(A_TXC, 8'h92);
    u_peer.q.delete();
    exp_q.delete();
    // Continuous receive of three words into the two-entry queue
    for (n = 0; n < 3; n++) rxb[n] = 8'($urandom);
    for (n = 0; n < 24; n++) u_peer.send.push_back(rxb[n / 8][n % 8]);
    apb(1'b1, A_RXC, 8'h90);
    wait_falls(24);
    `CHK(dt_oe, 1'b0)
    apb(1'b0, A_RXC, 8'h00);
    `CHK(rd[7:1], 7'h49)
    rchk(A_FLG, 8'h03);
    rchk(A_RXD, rxb[0]);
    rchk(A_RXD, rxb[1]);
    rchk(A_FLG, 8'h02);
    apb(1'b1, A_RXC, 8'h80);
    rchk(A_RXC, 8'h80);
    // Single receive of one word clears its own enable and stops the clock
    for (n = 0; n < 8; n++) u_peer.send.push_back(rxb[2][n]);
    apb(1'b1, A_RXC, 8'ha0);
    wait_falls(8);
    rchk(A_RXC, 8'h80);
    rchk(A_RXD, rxb[2]);
    `CHK(ck_oe, 1'b0)
    print_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule

// *** rtl/shift_clk_if.sv ***
// Shift clock timing shared between baud generator and shifters
`timescale 1ns/1ps
interface shift_clk_if;
  logic run;
  logic tick;
  logic rise;
  logic fall;
  logic level;

  modport gen (input run, output tick, output rise, output fall, output level);
  modport sink (input run, input tick, input rise, input fall, input level);
endinterface

// *** rtl/usart_brg.sv ***
// Baud rate generator making the shift clock phases
`timescale 1ns/1ps
module usart_brg (
  // Clock, reset and clock enable
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_clk_en,
  // Divider setting
  input  wire logic [7:0] i_divider,
  // Shift clock timing
  shift_clk_if.gen        sc
);

  logic [7:0] cnt_r;
  logic       level_r;

  // Tick ends each half period of the shift clock
  assign sc.tick  = sc.run & (cnt_r == i_divider);
  assign sc.rise  = sc.tick & ~level_r;
  assign sc.fall  = sc.tick & level_r;
  assign sc.level = level_r;

  // Counter held cleared while the port is idle
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      cnt_r   <= 8'h00;
      level_r <= 1'b0;
    end else if (i_clk_en) begin
      if (!sc.run) begin
        cnt_r   <= 8'h00;
        level_r <= 1'b0;
      end else if (sc.tick) begin
        cnt_r   <= 8'h00;
        level_r <= ~level_r;
      end else begin
        cnt_r   <= cnt_r + 8'h01;
      end
    end
  end

endmodule

// *** rtl/usart_defines.svh ***
// Register indices, field positions and reset values of the synchronous serial port
`ifndef USART_DEFINES_SVH
`define USART_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index, plus the bank offset in the second bank)
// ----------------------------------------------------------------
`define USART_IDX_RX_STAT   8'h13
`define USART_IDX_RX_DATA   8'h14
`define USART_IDX_TX_STAT   8'h15
`define USART_IDX_TX_DATA   8'h16
`define USART_IDX_FLAGS     8'h16
`define USART_IDX_BAUD      8'h17
`define USART_IDX_ENABLES   8'h17
// Byte offset added for the second register bank
`define USART_BANK1_OFS     8'h80

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define USART_RX_SERIAL_PORT_ENABLE       7
`define USART_RX_NINE_OPT   6
`define USART_RX_SINGLE     5
`define USART_RX_CONT       4
`define USART_RX_FRAMING_ERROR_FLAG       2
`define USART_RX_OVERRUN_ERROR_FLAG       1
`define USART_RX_NINTH      0
`define USART_TX_CLOCK_SOURCE_SELECT       7
`define USART_TX_NINE_OPT   6
`define USART_TX_EN         5
`define USART_TX_SYNC       4
`define USART_TX_SHIFTER_EMPTY_STATUS       1
`define USART_TX_NINTH      0
`define USART_FLAG_TX       1
`define USART_FLAG_RX       0

// ----------------------------------------------------------------
// Reset values and word lengths
// ----------------------------------------------------------------
`define USART_RX_STAT_RST   8'h00
`define USART_TX_STAT_RST   8'h02
`define USART_ENABLES_RST   8'h00
`define USART_BAUD_RST      8'h00
`define USART_TX_DATA_RST   8'h00
`define USART_BITS_8        4'h8
`define USART_BITS_9        4'h9

`endif

// *** rtl/usart_pkg.sv ***
// Types shared by the synchronous serial port modules
package usart_pkg;

  // Register selected by an APB address
  typedef enum logic [2:0] {
    REG_RX_STAT,
    REG_RX_DATA,
    REG_TX_STAT,
    REG_TX_DATA,
    REG_FLAGS,
    REG_BAUD,
    REG_ENABLES,
    REG_NONE
  } reg_sel_t;

  // Transmit shifter state
  typedef enum logic [1:0] {
    TX_EMPTY,
    TX_SHIFT
  } tx_state_t;

endpackage

// *** rtl/usart_sync_master.sv ***
// Synchronous master serial port with APB register access
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "usart_defines.svh"
module usart_sync_master
  import usart_pkg::*;
#(
  parameter int RX_DEPTH = 2
) (
  // Clock, reset and clock enable
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic        i_clk_en,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Shift clock pin
  output logic             o_clock_pin_out,
  output logic             o_clock_pin_oe,
  // Data pin
  input  wire logic        i_data_pin,
  output logic             o_data_pin_out,
  output logic             o_data_pin_oe
);

  localparam int PW = $clog2(RX_DEPTH);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  generate
    if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("RX_DEPTH must be a power of two of at least 2");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  shift_clk_if sc ();

  logic            serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r;
  logic            clock_source_select_r, tx9_r, transmit_enable_r, sync_r, transmit_ninth_bit_r;
  logic [7:0]      baud_r;
  logic [1:0]      pie_r;
  logic [7:0]      txbuf_r;
  logic            txbuf_full_r;
  tx_state_t       tx_state_r;
  logic [8:0]      tsr_r;
  logic [3:0]      tsr_cnt_r;
  logic            overrun_error_flag_r;
  logic [9:0]      rx_mem [RX_DEPTH];
  logic [PW-1:0]   wr_ptr_r, rd_ptr_r;
  logic [PW:0]     count_r;
  logic            d_meta_r, d_sync_r;
  logic            access, done, wr, rd;
  reg_sel_t        sel;
  logic [7:0]      wbyte, rd_byte;
  logic            tx_on, rx_req, master, tx_live, tx_load, tx_shift;
  logic            rx_valid;
  logic [8:0]      rx_word;
  logic            push, pop, overrun, fifo_full, fifo_any;
  logic [9:0]      head;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic reg_sel_t decode(input logic [7:0] a);
    case (a)
      8'(`USART_IDX_RX_STAT << 2):                      decode = REG_RX_STAT;
      8'(`USART_IDX_RX_DATA << 2):                      decode = REG_RX_DATA;
      8'(`USART_IDX_TX_STAT << 2):                      decode = REG_TX_STAT;
      8'(`USART_IDX_TX_DATA << 2):                      decode = REG_TX_DATA;
      8'(`USART_IDX_BAUD << 2):                         decode = REG_BAUD;
      8'((`USART_IDX_FLAGS << 2) + `USART_BANK1_OFS):   decode = REG_FLAGS;
      8'((`USART_IDX_ENABLES << 2) + `USART_BANK1_OFS): decode = REG_ENABLES;
      default:                                          decode = REG_NONE;
    endcase
  endfunction

  // APB phases: one wait state, effects at the completing edge
  assign access = i_psel & i_penable;
  assign done   = access & o_pready;
  assign wr     = done & i_pwrite;
  assign rd     = done & ~i_pwrite;
  assign sel    = decode(i_paddr);
  assign wbyte  = i_pwdata[7:0];

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign tx_on   = serial_port_enable_r & transmit_enable_r;
  assign rx_req  = continuous_receive_enable_r | single_receive_enable_r;
  assign master  = serial_port_enable_r & sync_r & clock_source_select_r;
  assign sc.run  = master & (transmit_enable_r | rx_req);
  assign tx_live = master & tx_on & ~rx_req;

  // Shifter load at a baud tick once the previous word has left
  assign tx_load = tx_live & sc.tick & txbuf_full_r &
                   ((tx_state_r == TX_EMPTY) || (sc.fall && tsr_cnt_r == 4'h0));
  assign tx_shift = tx_live & sc.rise & (tx_state_r == TX_SHIFT) & (tsr_cnt_r != 4'h0);

  // Receive queue control
  assign fifo_full = (count_r == (PW + 1)'(RX_DEPTH));
  assign fifo_any  = (count_r != '0);
  assign overrun   = rx_valid & (overrun_error_flag_r | fifo_full);
  assign push      = rx_valid & ~overrun_error_flag_r & ~fifo_full;
  assign pop       = rd & (sel == REG_RX_DATA) & fifo_any;
  assign head      = rx_mem[rd_ptr_r];

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  usart_brg u_brg (
    .i_clock   (i_clock),
    .i_rst_b   (i_rst_b),
    .i_clk_en  (i_clk_en),
    .i_divider (baud_r),
    .sc        (sc)
  );

  usart_sync_rx u_rx (
    .i_clock  (i_clock),
    .i_rst_b  (i_rst_b),
    .i_clk_en (i_clk_en),
    .i_enable (master & rx_req),
    .i_nine   (rx9_r),
    .i_data   (d_sync_r),
    .sc       (sc),
    .o_valid  (rx_valid),
    .o_word   (rx_word)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Read data mux
  always_comb begin
    rd_byte = 8'h00;
    case (sel)
      REG_RX_STAT: begin
        rd_byte[`USART_RX_SERIAL_PORT_ENABLE]     = serial_port_enable_r;
        rd_byte[`USART_RX_NINE_OPT] = rx9_r;
        rd_byte[`USART_RX_SINGLE]   = single_receive_enable_r;
        rd_byte[`USART_RX_CONT]     = continuous_receive_enable_r;
        rd_byte[`USART_RX_FRAMING_ERROR_FLAG]     = fifo_any & head[9];
        rd_byte[`USART_RX_OVERRUN_ERROR_FLAG]     = overrun_error_flag_r;
        rd_byte[`USART_RX_NINTH]    = fifo_any & head[8];
      end
      REG_RX_DATA: rd_byte = head[7:0];
      REG_TX_STAT: begin
        rd_byte[`USART_TX_CLOCK_SOURCE_SELECT]     = clock_source_select_r;
        rd_byte[`USART_TX_NINE_OPT] = tx9_r;
        rd_byte[`USART_TX_EN]       = transmit_enable_r;
        rd_byte[`USART_TX_SYNC]     = sync_r;
        rd_byte[`USART_TX_SHIFTER_EMPTY_STATUS]     = (tx_state_r == TX_EMPTY);
        rd_byte[`USART_TX_NINTH]    = transmit_ninth_bit_r;
      end
      REG_TX_DATA: rd_byte = txbuf_r;
      REG_FLAGS: begin
        rd_byte[`USART_FLAG_TX]     = ~txbuf_full_r;
        rd_byte[`USART_FLAG_RX]     = fifo_any;
      end
      REG_BAUD:    rd_byte = baud_r;
      REG_ENABLES: rd_byte = {6'h00, pie_r};
      default:     rd_byte = 8'h00;
    endcase
  end

  // Ready, read data and error registered in the first access cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_clk_en) begin
      o_pready  <= access & ~o_pready;
      o_pslverr <= access & ~o_pready & (sel == REG_NONE);
      if (access && !o_pready && !i_pwrite) begin
        o_prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Receive control, single receive clears after its word
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      serial_port_enable_r <= 1'(`USART_RX_STAT_RST >> `USART_RX_SERIAL_PORT_ENABLE);
      rx9_r  <= 1'(`USART_RX_STAT_RST >> `USART_RX_NINE_OPT);
      single_receive_enable_r <= 1'(`USART_RX_STAT_RST >> `USART_RX_SINGLE);
      continuous_receive_enable_r <= 1'(`USART_RX_STAT_RST >> `USART_RX_CONT);
    end else if (i_clk_en) begin
      if (wr && sel == REG_RX_STAT) begin
        serial_port_enable_r <= wbyte[`USART_RX_SERIAL_PORT_ENABLE];
        rx9_r  <= wbyte[`USART_RX_NINE_OPT];
        single_receive_enable_r <= wbyte[`USART_RX_SINGLE];
        continuous_receive_enable_r <= wbyte[`USART_RX_CONT];
      end else if (rx_valid && !continuous_receive_enable_r) begin
        single_receive_enable_r <= 1'b0;
      end
    end
  end

  // Transmit control
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      clock_source_select_r <= 1'(`USART_TX_STAT_RST >> `USART_TX_CLOCK_SOURCE_SELECT);
      tx9_r  <= 1'(`USART_TX_STAT_RST >> `USART_TX_NINE_OPT);
      transmit_enable_r <= 1'(`USART_TX_STAT_RST >> `USART_TX_EN);
      sync_r <= 1'(`USART_TX_STAT_RST >> `USART_TX_SYNC);
      transmit_ninth_bit_r <= 1'(`USART_TX_STAT_RST >> `USART_TX_NINTH);
    end else if (i_clk_en && wr && sel == REG_TX_STAT) begin
      clock_source_select_r <= wbyte[`USART_TX_CLOCK_SOURCE_SELECT];
      tx9_r  <= wbyte[`USART_TX_NINE_OPT];
      transmit_enable_r <= wbyte[`USART_TX_EN];
      sync_r <= wbyte[`USART_TX_SYNC];
      transmit_ninth_bit_r <= wbyte[`USART_TX_NINTH];
    end
  end

  // Divider and enable bits
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      baud_r <= `USART_BAUD_RST;
      pie_r  <= 2'(`USART_ENABLES_RST);
    end else if (i_clk_en && wr) begin
      if (sel == REG_BAUD) begin
        baud_r <= wbyte;
      end
      if (sel == REG_ENABLES) begin
        pie_r <= wbyte[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  // Transmit buffer; a write in the load cycle refills it
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      txbuf_r      <= `USART_TX_DATA_RST;
      txbuf_full_r <= 1'b0;
    end else if (i_clk_en) begin
      if (wr && sel == REG_TX_DATA) begin
        txbuf_r      <= wbyte;
        txbuf_full_r <= 1'b1;
      end else if (tx_load) begin
        txbuf_full_r <= 1'b0;
      end
    end
  end

  // Transmit shifter; new bit on rising, held through falling edge
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      tx_state_r     <= TX_EMPTY;
      tsr_r          <= 9'h000;
      tsr_cnt_r      <= 4'h0;
      o_data_pin_out <= 1'b0;
    end else if (i_clk_en) begin
      if (!tx_on) begin
        tx_state_r <= TX_EMPTY;
        tsr_cnt_r  <= 4'h0;
      end else if (tx_load) begin
        tx_state_r <= TX_SHIFT;
        tsr_r      <= {transmit_ninth_bit_r, txbuf_r};
        tsr_cnt_r  <= tx9_r ? `USART_BITS_9 : `USART_BITS_8;
      end else begin
        case (tx_state_r)
          TX_EMPTY: tsr_cnt_r <= 4'h0;
          TX_SHIFT: begin
            if (tx_live && sc.rise && tsr_cnt_r != 4'h0) begin
              o_data_pin_out <= tsr_r[0];
              tsr_r          <= {1'b0, tsr_r[8:1]};
              tsr_cnt_r      <= tsr_cnt_r - 4'h1;
            end else if (tx_live && sc.fall && tsr_cnt_r == 4'h0) begin
              tx_state_r <= TX_EMPTY;
            end
          end
          default: tx_state_r <= TX_EMPTY;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Pin drivers and data line synchroniser
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_clock_pin_out <= 1'b0;
      o_clock_pin_oe  <= 1'b0;
      o_data_pin_oe   <= 1'b0;
      d_meta_r        <= 1'b0;
      d_sync_r        <= 1'b0;
    end else if (i_clk_en) begin
      o_clock_pin_out <= sc.run & (rx_req ? (sc.level ^ sc.tick) : (tx_shift | (o_clock_pin_out & ~sc.fall)));
      o_clock_pin_oe  <= sc.run;
      o_data_pin_oe   <= tx_live;
      d_meta_r        <= i_data_pin;
      d_sync_r        <= d_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Receive queue
  // ----------------------------------------------------------------
  // RX_DEPTH-entry queue of data, ninth bit and framing status
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (i_clk_en) begin
      if (push) begin
        rx_mem[wr_ptr_r] <= {1'b0, rx9_r & rx_word[8], rx_word[7:0]};
        wr_ptr_r         <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // Overrun flag; a new overrun wins over the clearing write
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      overrun_error_flag_r <= 1'b0;
    end else if (i_clk_en) begin
      if (overrun) begin
        overrun_error_flag_r <= 1'b1;
      end else if (!serial_port_enable_r || (wr && sel == REG_RX_STAT && !wbyte[`USART_RX_CONT])) begin
        overrun_error_flag_r <= 1'b0;
      end
    end
  end

endmodule

// *** rtl/usart_sync_rx.sv ***
// Receive shifter sampling the data line on falling shift clock edges
`timescale 1ns/1ps
`include "usart_defines.svh"
module usart_sync_rx (
  // Clock, reset and clock enable
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_clk_en,
  // Control and synchronised data line
  input  wire logic       i_enable,
  input  wire logic       i_nine,
  input  wire logic       i_data,
  // Shift clock timing
  shift_clk_if.sink       sc,
  // Completed word
  output logic            o_valid,
  output logic      [8:0] o_word
);

  logic [8:0] shreg_r;
  logic [3:0] cnt_r;
  logic [8:0] shreg_nxt;
  logic [3:0] nbits;

  assign shreg_nxt = {i_data, shreg_r[8:1]};
  assign nbits     = i_nine ? `USART_BITS_9 : `USART_BITS_8;

  // Shift in least significant bit first, reset while disabled
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      shreg_r <= 9'h000;
      cnt_r   <= 4'h0;
      o_valid <= 1'b0;
      o_word  <= 9'h000;
    end else if (i_clk_en) begin
      o_valid <= 1'b0;
      if (!i_enable) begin
        cnt_r <= 4'h0;
      end else if (sc.fall) begin
        shreg_r <= shreg_nxt;
        if (cnt_r == nbits - 4'h1) begin
          cnt_r   <= 4'h0;
          o_valid <= 1'b1;
          o_word  <= i_nine ? shreg_nxt : {1'b0, shreg_nxt[8:1]};
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end

endmodule
